/* File: hw/dcr_pkg.sv */
/*
 * Constants, region codes and address decode for the dual-core
 * interrupt router.
 * Assumes a 10-bit byte address from an AXI4-Lite slave front end.
 */
// Contract
// - 175 sources; source n drives main processor request line n unchanged.
// - eight secondary request lines, each an OR over a selectable source set.
// - eight software-only interrupts toward the secondary processor.
// - priority per interrupt: eight levels main, four levels secondary.
// - up to four selectable system sources per core feed its NMI.
// - sources 0..44 may wake the device from deep sleep.
// - sixteen link channels and sixteen link interrupt structures.
// - channel lock is taken before shared use; others respect a held lock.
// - one core interrupts the other for channel notify and release events.
// - system function request from a core or debug port raises secondary NMI.
`default_nettype none
package dcr_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NSRC = 175;
  localparam int NSEC = 8;
  localparam int NCH = 16;
  localparam int NWAKE = 45;
  localparam int NSLOT = 4;
  localparam int AW = 10;
  localparam int PRIO_W = 3;
  localparam int SPRIO_W = 2;
  localparam int PRIO_WORDS = 22;
  localparam int MUX_WORDS = 6;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [AW-1:0] A_PRIO = 10'h000;
  localparam logic [AW-1:0] PRIO_END = 10'h058;
  localparam logic [AW-1:0] A_MUX = 10'h080;
  localparam logic [AW-1:0] MUX_END = 10'h140;
  localparam logic [AW-1:0] A_SPRIO = 10'h140;
  localparam logic [AW-1:0] A_SWINT = 10'h144;
  localparam logic [AW-1:0] A_NMI_MSEL = 10'h148;
  localparam logic [AW-1:0] A_NMI_SSEL = 10'h14C;
  localparam logic [AW-1:0] A_NMI_EN = 10'h150;
  localparam logic [AW-1:0] A_WAKE_LO = 10'h154;
  localparam logic [AW-1:0] A_WAKE_HI = 10'h158;
  localparam logic [AW-1:0] A_SYS_PEND = 10'h15C;
  localparam logic [AW-1:0] A_SYS_REQ = 10'h160;
  localparam logic [AW-1:0] A_EVT_STAT = 10'h164;
  localparam logic [AW-1:0] A_EVT_MASK = 10'h168;
  localparam logic [AW-1:0] A_CHAN = 10'h200;
  localparam logic [AW-1:0] A_ISTR = 10'h300;

  // channel word within its 16-byte slot
  localparam logic [1:0] CH_LOCK = 2'h0;
  localparam logic [1:0] CH_DATA = 2'h1;
  localparam logic [1:0] CH_NOTIFY = 2'h2;
  localparam logic [1:0] CH_REL = 2'h3;

  // ****************************************************************
  // field positions, masks and reset value
  // ****************************************************************
  localparam int LK_HELD = 0;
  localparam int LK_OWNER = 1;
  localparam int REL_OWNER = 16;
  localparam int EVT_REFUSE = 0;
  localparam int EVT_BADREL = 1;
  localparam int EVT_DBG = 2;
  localparam int SYS_DBG = 2;
  localparam int SEL_W = 8;
  localparam logic [31:0] PRIO_MASK = 32'h77777777;
  localparam logic [31:0] SPRIO_MASK = 32'h33333333;
  localparam logic [31:0] MUX_LAST_MASK = 32'h00007FFF;
  localparam logic [31:0] SWINT_MASK = 32'h000000FF;
  localparam logic [31:0] NMI_EN_MASK = 32'h000000FF;
  localparam logic [31:0] WAKE_HI_MASK = 32'h00001FFF;
  localparam logic [31:0] SYS_SW_MASK = 32'h00000003;
  localparam logic [31:0] SYS_MASK = 32'h00000007;
  localparam logic [31:0] EVT_BITS = 32'h00000007;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    RG_NONE = 4'h0,
    RG_PRIO = 4'h1,
    RG_MUX = 4'h2,
    RG_SPRIO = 4'h3,
    RG_SWINT = 4'h4,
    RG_NMI_MSEL = 4'h5,
    RG_NMI_SSEL = 4'h6,
    RG_NMI_EN = 4'h7,
    RG_WAKE_LO = 4'h8,
    RG_WAKE_HI = 4'h9,
    RG_SYS_PEND = 4'hA,
    RG_SYS_REQ = 4'hB,
    RG_EVT_STAT = 4'hC,
    RG_EVT_MASK = 4'hD,
    RG_CHAN = 4'hE,
    RG_ISTR = 4'hF
  } dcr_region_t;

  function automatic dcr_region_t dcr_region(input logic [AW-1:0] a);
    dcr_region_t rg;
    rg = RG_NONE;
    if (a < PRIO_END) begin
      rg = RG_PRIO;
    end else if (a >= A_MUX && a < MUX_END) begin
      rg = RG_MUX;
    end else if (a[AW-1:8] == A_CHAN[AW-1:8]) begin
      rg = RG_CHAN;
    end else if (a[AW-1:7] == A_ISTR[AW-1:7]) begin
      rg = RG_ISTR;
    end else begin
      case ({a[AW-1:2], 2'h0})
        A_SPRIO: rg = RG_SPRIO;
        A_SWINT: rg = RG_SWINT;
        A_NMI_MSEL: rg = RG_NMI_MSEL;
        A_NMI_SSEL: rg = RG_NMI_SSEL;
        A_NMI_EN: rg = RG_NMI_EN;
        A_WAKE_LO: rg = RG_WAKE_LO;
        A_WAKE_HI: rg = RG_WAKE_HI;
        A_SYS_PEND: rg = RG_SYS_PEND;
        A_SYS_REQ: rg = RG_SYS_REQ;
        A_EVT_STAT: rg = RG_EVT_STAT;
        A_EVT_MASK: rg = RG_EVT_MASK;
        default: rg = RG_NONE;
      endcase
    end
    return rg;
  endfunction

endpackage
`default_nettype wire

/* File: hw/dcr_axil_slave.sv */
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the register file answers decode and read data in the
 * same cycle as the request.
 */
`timescale 1ns/100ps
`default_nettype none
module dcr_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dcr_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcr_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [dcr_pkg::AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [dcr_pkg::AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import dcr_pkg::*;

  logic aw_full;
  logic w_full;
  logic rd_take;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_en = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // ****************************************************************
  // write channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : RST_ZERO;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: hw/dcr_irq_router.sv */
/*
 * Dual-core interrupt router: direct main-core routing, secondary
 * source muxes, priorities, NMI selection, deep-sleep wake, and the
 * inter-processor channels with locks and interrupt structures.
 * Assumes src_irq is synchronous to aclk and level-active high.
 */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module dcr_irq_router (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dcr_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dcr_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [dcr_pkg::NSRC-1:0] src_irq,
  input wire logic dbg_sysfunc_req,
  input wire logic deep_sleep,
  output logic [dcr_pkg::NSRC-1:0] main_irq,
  output logic [dcr_pkg::NSRC*dcr_pkg::PRIO_W-1:0] main_prio,
  output logic main_nmi,
  output logic [dcr_pkg::NSEC-1:0] sec_irq,
  output logic [dcr_pkg::NSEC*dcr_pkg::SPRIO_W-1:0] sec_prio,
  output logic [dcr_pkg::NSEC-1:0] sec_sw_irq,
  output logic sec_nmi,
  output logic wake_req,
  output logic [dcr_pkg::NCH-1:0] link_irq,
  output logic irq
);
  import dcr_pkg::*;

  // ****************************************************************
  // bus front end and decode
  // ****************************************************************
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  dcr_axil_slave dcr_axil_slave_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  dcr_region_t w_rg;
  dcr_region_t r_rg;
  logic [AW-1:0] w_moff;
  logic [AW-1:0] r_moff;
  logic [31:0] wmask;
  logic [31:0] wbits;

  assign w_rg = wr_en ? dcr_region(wr_addr) : RG_NONE;
  assign r_rg = dcr_region(rd_addr);
  assign wr_ok = dcr_region(wr_addr) != RG_NONE;
  assign rd_ok = r_rg != RG_NONE;
  assign w_moff = wr_addr - A_MUX;
  assign r_moff = rd_addr - A_MUX;
  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                  {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wbits = wr_data & wmask;

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [31:0] prio_q [PRIO_WORDS];
  logic [31:0] next_prio [PRIO_WORDS];
  logic [31:0] mux_q [NSEC*MUX_WORDS];
  logic [31:0] next_mux [NSEC*MUX_WORDS];
  logic [31:0] cdata_q [NCH];
  logic [31:0] next_cdata [NCH];
  logic [31:0] istat_q [NCH];
  logic [31:0] next_istat [NCH];
  logic [31:0] imask_q [NCH];
  logic [31:0] next_imask [NCH];
  logic [NCH-1:0] held;
  logic [NCH-1:0] next_held;
  logic [NCH-1:0] owner;
  logic [NCH-1:0] next_owner;
  logic [31:0] sprio_q, swint_q, msel_q, ssel_q, nmi_en_q;
  logic [31:0] wake_lo_q, wake_hi_q, sys_pend_q, evt_stat_q, evt_mask_q;
  logic [31:0] next_sprio, next_swint, next_msel, next_ssel, next_nmi_en;
  logic [31:0] next_wake_lo, next_wake_hi, next_sys_pend;
  logic [31:0] next_evt_stat, next_evt_mask;

  // ****************************************************************
  // priorities and secondary mux words
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < PRIO_WORDS; i++) begin : g_prio
      assign next_prio[i] = (w_rg == RG_PRIO && wr_addr[6:2] == i) ?
        ((prio_q[i] & ~wmask) | wbits) & PRIO_MASK : prio_q[i];
    end
    for (i = 0; i < NSEC*MUX_WORDS; i++) begin : g_muxw
      localparam logic [31:0] MK =
        (i % MUX_WORDS == MUX_WORDS-1) ? MUX_LAST_MASK : '1;
      assign next_mux[i] = (w_rg == RG_MUX && w_moff[7:2] == i) ?
        ((mux_q[i] & ~wmask) | wbits) & MK : mux_q[i];
    end
    for (i = 0; i < NSRC; i++) begin : g_mprio
      assign main_prio[i*PRIO_W +: PRIO_W] =
        prio_q[i/8][(i%8)*4 +: PRIO_W];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_q <= '{default: RST_ZERO};
      mux_q <= '{default: RST_ZERO};
    end else begin
      prio_q <= next_prio;
      mux_q <= next_mux;
    end
  end

  // ****************************************************************
  // secondary lines, software interrupts, NMI selection
  // ****************************************************************
  logic [NSEC-1:0] sec_line;
  logic [255:0] src_ext;
  logic [NSLOT-1:0] mnmi;
  logic [NSLOT-1:0] snmi;

  assign src_ext = 256'(src_irq);

  generate
    for (i = 0; i < NSEC; i++) begin : g_sec
      logic [MUX_WORDS*32-1:0] selv;
      for (genvar w = 0; w < MUX_WORDS; w++) begin : g_w
        assign selv[w*32 +: 32] = mux_q[i*MUX_WORDS + w];
      end
      assign sec_line[i] = |(src_irq & selv[NSRC-1:0]);
      assign sec_prio[i*SPRIO_W +: SPRIO_W] =
        sprio_q[i*4 +: SPRIO_W];
    end
    for (i = 0; i < NSLOT; i++) begin : g_nmi
      assign mnmi[i] = nmi_en_q[i] &&
        src_ext[msel_q[i*SEL_W +: SEL_W]];
      assign snmi[i] = nmi_en_q[NSLOT+i] &&
        src_ext[ssel_q[i*SEL_W +: SEL_W]];
    end
  endgenerate

  assign sec_sw_irq = swint_q[NSEC-1:0];

  // ****************************************************************
  // inter-processor channels and locks
  // ****************************************************************
  logic [NCH-1:0] lk_take;
  logic [NCH-1:0] lk_refuse;
  logic [NCH-1:0] rel_ok;
  logic [NCH-1:0] rel_bad;
  logic [NCH-1:0] ntf;
  logic [NCH-1:0] link_c;

  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic hit;
      logic match;
      assign hit = w_rg == RG_CHAN && wr_addr[7:4] == i;
      assign match = owner[i] == wr_data[REL_OWNER];
      assign lk_take[i] = hit && wr_addr[3:2] == CH_LOCK && !held[i];
      assign lk_refuse[i] = hit && wr_addr[3:2] == CH_LOCK && held[i];
      assign rel_ok[i] = hit && wr_addr[3:2] == CH_REL && held[i] && match;
      assign rel_bad[i] = hit && wr_addr[3:2] == CH_REL &&
        !(held[i] && match);
      assign ntf[i] = hit && wr_addr[3:2] == CH_NOTIFY;
      assign next_held[i] = lk_take[i] | (held[i] & ~rel_ok[i]);
      assign next_owner[i] = lk_take[i] ? wr_data[LK_OWNER] : owner[i];
      assign next_cdata[i] = (hit && wr_addr[3:2] == CH_DATA) ?
        (cdata_q[i] & ~wmask) | wbits : cdata_q[i];
    end

    // structure s collects notify/release of every channel whose
    // command write selects bit s
    for (i = 0; i < NCH; i++) begin : g_istr
      logic hit;
      logic [31:0] iset;
      logic [31:0] iclr;
      assign hit = w_rg == RG_ISTR && wr_addr[6:3] == i;
      assign iset = {rel_ok & {NCH{wr_data[i]}},
                     ntf & {NCH{wr_data[i]}}};
      assign iclr = (hit && !wr_addr[2]) ? wbits : RST_ZERO;
      assign next_istat[i] = (istat_q[i] & ~iclr) | iset;
      assign next_imask[i] = (hit && wr_addr[2]) ?
        (imask_q[i] & ~wmask) | wbits : imask_q[i];
      assign link_c[i] = |(istat_q[i] & imask_q[i]);
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= '0;
      owner <= '0;
      cdata_q <= '{default: RST_ZERO};
      istat_q <= '{default: RST_ZERO};
      imask_q <= '{default: RST_ZERO};
    end else begin
      held <= next_held;
      owner <= next_owner;
      cdata_q <= next_cdata;
      istat_q <= next_istat;
      imask_q <= next_imask;
    end
  end

  // ****************************************************************
  // single control and status words
  // ****************************************************************
  logic [31:0] evt_set;
  logic [31:0] sys_set;

  assign next_sprio = (w_rg == RG_SPRIO) ?
    ((sprio_q & ~wmask) | wbits) & SPRIO_MASK : sprio_q;
  assign next_swint = (w_rg == RG_SWINT) ?
    ((swint_q & ~wmask) | wbits) & SWINT_MASK : swint_q;
  assign next_msel = (w_rg == RG_NMI_MSEL) ?
    (msel_q & ~wmask) | wbits : msel_q;
  assign next_ssel = (w_rg == RG_NMI_SSEL) ?
    (ssel_q & ~wmask) | wbits : ssel_q;
  assign next_nmi_en = (w_rg == RG_NMI_EN) ?
    ((nmi_en_q & ~wmask) | wbits) & NMI_EN_MASK : nmi_en_q;
  assign next_wake_lo = (w_rg == RG_WAKE_LO) ?
    (wake_lo_q & ~wmask) | wbits : wake_lo_q;
  assign next_wake_hi = (w_rg == RG_WAKE_HI) ?
    ((wake_hi_q & ~wmask) | wbits) & WAKE_HI_MASK : wake_hi_q;
  assign next_evt_mask = (w_rg == RG_EVT_MASK) ?
    ((evt_mask_q & ~wmask) | wbits) & EVT_BITS : evt_mask_q;

  // sticky bits: a set in the clearing cycle survives
  assign sys_set = ((w_rg == RG_SYS_REQ) ? wbits & SYS_SW_MASK : RST_ZERO)
    | (32'(dbg_sysfunc_req) << SYS_DBG);
  assign next_sys_pend = ((sys_pend_q &
    ~((w_rg == RG_SYS_PEND) ? wbits : RST_ZERO)) | sys_set) & SYS_MASK;
  assign evt_set = (32'(|lk_refuse) << EVT_REFUSE)
    | (32'(|rel_bad) << EVT_BADREL) | (32'(dbg_sysfunc_req) << EVT_DBG);
  assign next_evt_stat = ((evt_stat_q &
    ~((w_rg == RG_EVT_STAT) ? wbits : RST_ZERO)) | evt_set) & EVT_BITS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sprio_q <= RST_ZERO;
      swint_q <= RST_ZERO;
      msel_q <= RST_ZERO;
      ssel_q <= RST_ZERO;
      nmi_en_q <= RST_ZERO;
      wake_lo_q <= RST_ZERO;
      wake_hi_q <= RST_ZERO;
      sys_pend_q <= RST_ZERO;
      evt_stat_q <= RST_ZERO;
      evt_mask_q <= RST_ZERO;
    end else begin
      sprio_q <= next_sprio;
      swint_q <= next_swint;
      msel_q <= next_msel;
      ssel_q <= next_ssel;
      nmi_en_q <= next_nmi_en;
      wake_lo_q <= next_wake_lo;
      wake_hi_q <= next_wake_hi;
      sys_pend_q <= next_sys_pend;
      evt_stat_q <= next_evt_stat;
      evt_mask_q <= next_evt_mask;
    end
  end

  // ****************************************************************
  // read data selection
  // ****************************************************************
  logic [3:0] r_ch;
  logic [31:0] r_chan_v;
  logic [31:0] lock_word;

  assign r_ch = rd_addr[7:4];
  assign lock_word = (32'(owner[r_ch]) << LK_OWNER)
    | (32'(held[r_ch]) << LK_HELD);
  assign r_chan_v = (rd_addr[3:2] == CH_LOCK) ? lock_word :
    (rd_addr[3:2] == CH_DATA) ? cdata_q[r_ch] : RST_ZERO;

  assign rd_data =
    (r_rg == RG_PRIO) ? prio_q[rd_addr[6:2]] :
    (r_rg == RG_MUX) ? mux_q[r_moff[7:2]] :
    (r_rg == RG_CHAN) ? r_chan_v :
    (r_rg == RG_ISTR) ?
      (rd_addr[2] ? imask_q[rd_addr[6:3]] : istat_q[rd_addr[6:3]]) :
    (r_rg == RG_SPRIO) ? sprio_q :
    (r_rg == RG_SWINT) ? swint_q :
    (r_rg == RG_NMI_MSEL) ? msel_q :
    (r_rg == RG_NMI_SSEL) ? ssel_q :
    (r_rg == RG_NMI_EN) ? nmi_en_q :
    (r_rg == RG_WAKE_LO) ? wake_lo_q :
    (r_rg == RG_WAKE_HI) ? wake_hi_q :
    (r_rg == RG_SYS_PEND) ? sys_pend_q :
    (r_rg == RG_EVT_STAT) ? evt_stat_q :
    (r_rg == RG_EVT_MASK) ? evt_mask_q : RST_ZERO;

  // ****************************************************************
  // registered interrupt outputs
  // ****************************************************************
  logic [NWAKE-1:0] wake_en;

  assign wake_en = {wake_hi_q[NWAKE-33:0], wake_lo_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_irq <= '0;
      sec_irq <= '0;
      main_nmi <= 1'b0;
      sec_nmi <= 1'b0;
      wake_req <= 1'b0;
      link_irq <= '0;
      irq <= 1'b0;
    end else begin
      main_irq <= src_irq;
      sec_irq <= sec_line;
      main_nmi <= |mnmi;
      sec_nmi <= (|snmi) | (|sys_pend_q);
      wake_req <= deep_sleep && |(src_irq[NWAKE-1:0] & wake_en);
      link_irq <= link_c;
      irq <= |(evt_stat_q & evt_mask_q);
    end
  end

endmodule
`default_nettype wire

/* File: bench/dcr_irq_router_assertions.sv */
/* port assertions for the interrupt router
   assumes binding onto dcr_irq_router */
`timescale 1ns/100ps
`default_nettype none
module dcr_irq_router_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dcr_pkg::NSRC-1:0] src_irq,
  input wire logic dbg_sysfunc_req,
  input wire logic deep_sleep,
  input wire logic [dcr_pkg::NSRC-1:0] main_irq,
  input wire logic main_nmi,
  input wire logic [dcr_pkg::NSEC-1:0] sec_irq,
  input wire logic sec_nmi,
  input wire logic wake_req,
  input wire logic [dcr_pkg::NCH-1:0] link_irq,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dcr_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_main_direct: assert property (
    $past(aresetn) |-> main_irq == $past(src_irq)) else $error("main route");
  a_wake_gate: assert property (
    $past(aresetn) && !$past(deep_sleep) |-> !wake_req) else $error("wake");
  a_wake_range: assert property (
    $past(aresetn) && $past(src_irq[44:0]) == 0 |-> !wake_req)
    else $error("wake range");
  a_sec_quiet: assert property (
    $past(aresetn) && $past(src_irq) == 0 |-> sec_irq == 0)
    else $error("sec line");
  a_nmi_quiet: assert property (
    $past(aresetn) && $past(src_irq) == 0 |-> !main_nmi)
    else $error("main nmi");
  a_dbg_nmi: assert property (
    $rose(dbg_sysfunc_req) |-> ##[1:3] sec_nmi) else $error("debug nmi");
  a_bresp_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
  a_rresp_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid");
  c_wake: cover property (wake_req);
  c_sec_nmi: cover property (sec_nmi);
  c_link: cover property (link_irq != 0);
endmodule
bind dcr_irq_router dcr_irq_router_assertions dcr_irq_router_assertions_i (.*);
`default_nettype wire

/* File: bench/dcr_core_model.sv */
/* secondary core: counts entries into its nmi handler
   assumes sec_nmi synchronous to aclk */
`timescale 1ns/100ps
`default_nettype none
module dcr_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sec_nmi,
  output logic [7:0] nmi_n
);
  logic nmi_q;
  always_ff @(posedge aclk) begin
    nmi_q <= aresetn && sec_nmi;
    if (!aresetn) nmi_n <= 8'h00;
    else if (sec_nmi && !nmi_q) nmi_n <= nmi_n + 8'h01;
  end
endmodule
`default_nettype wire

/* File: bench/dcr_irq_router_test.sv */
/* self-checking bench for the interrupt router
   assumes dcr_pkg, the bound checker and the core model */
`timescale 1ns/100ps
`default_nettype none
module dcr_irq_router_test;
  import dcr_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic dbg = 0, ds = 0, awready, wready, bvalid, arready, rvalid;
  logic main_nmi, sec_nmi, wake_req, irq;
  logic [AW-1:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [NSRC-1:0] src = 0, main_irq;
  logic [1:0] bresp, rresp, rs;
  logic [NSEC-1:0] sec_irq, sw;
  logic [15:0] link_irq, spr;
  logic [NSRC*PRIO_W-1:0] mp;
  logic [7:0] nmi_n;
  logic [191:0] rnd;
  int errors = 0, n_compared = 0, cyc = 0;
  always #50 aclk = ~aclk;
  dcr_irq_router dcr_irq_router_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .src_irq(src),
    .dbg_sysfunc_req(dbg), .deep_sleep(ds), .main_irq(main_irq),
    .main_prio(mp), .main_nmi(main_nmi), .sec_irq(sec_irq), .sec_prio(spr),
    .sec_sw_irq(sw), .sec_nmi(sec_nmi), .wake_req(wake_req),
    .link_irq(link_irq), .irq(irq));
  dcr_core_model dcr_core_model_i (.aclk(aclk), .aresetn(aresetn),
    .sec_nmi(sec_nmi), .nmi_n(nmi_n));
  function automatic logic [NSEC-1:0] sec_exp(input logic [NSRC-1:0] s);
    sec_exp = {1'b0, s[6:1], s[0] | s[NSRC-1]};
  endfunction
  function automatic logic [23:0] pr_exp(input logic [31:0] v, int w);
    pr_exp = '0;
    for (int j = 0; j < 8 * w; j++) pr_exp[j] = v[4 * (j / w) + j % w];
  endfunction
  task automatic finish_test;
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ck(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t unexpected value", $time);
    end
  endtask
  task automatic w8(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a,
    input logic [31:0] v);
    logic ta, tw, tr, tb;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= v;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      tb = w ? bvalid : rvalid;
      rs = w ? bresp : rresp;
      d = rdata;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
    end while (!tb);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    d = $urandom(50);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, A_PRIO, 0);
    ck(d === RST_ZERO && rs === RESP_OKAY);
    rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    bus(1, A_PRIO, rnd[31:0]);
    bus(0, A_PRIO, 0);
    ck(d === (rnd[31:0] & PRIO_MASK));
    ck(mp[23:0] === pr_exp(rnd[31:0], 3));
    bus(1, A_SPRIO, rnd[63:32]);
    bus(0, A_SPRIO, 0);
    ck(d === (rnd[63:32] & SPRIO_MASK));
    ck(spr === 16'(pr_exp(rnd[63:32], 2)));
    bus(1, A_SWINT, 32'hA5);
    w8(1);
    ck(sw === 8'hA5);
    for (int l = 0; l < 7; l++) begin
      bus(1, AW'(A_MUX + 24 * l), 32'h1 << l);
    end
    bus(1, A_MUX + 10'h014, 32'h4000);
    for (int i = 0; i < 20; i++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      if (i < 2) rnd = {192{i[0]}};
      @(posedge aclk);
      src <= rnd[NSRC-1:0];
      w8(1);
      ck(main_irq === src && sec_irq === sec_exp(src));
    end
    @(posedge aclk);
    src <= '0;
    bus(1, A_NMI_MSEL, 32'hFFAE);
    bus(1, A_NMI_SSEL, 32'h05);
    bus(1, A_NMI_EN, 32'h13);
    w8(1);
    ck(!main_nmi && !sec_nmi);
    @(posedge aclk);
    src[NSRC-1] <= 1'b1;
    src[5] <= 1'b1;
    w8(1);
    ck(main_nmi && sec_nmi && main_irq === src);
    @(posedge aclk);
    src <= '0;
    bus(1, A_WAKE_HI, 32'h1000);
    src[44] <= 1'b1;
    w8(1);
    ck(!wake_req);
    @(posedge aclk);
    ds <= 1'b1;
    w8(1);
    ck(wake_req);
    @(posedge aclk);
    src <= src << 1;
    w8(1);
    ck(!wake_req);
    @(posedge aclk);
    src <= '0;
    ds <= 1'b0;
    bus(1, A_EVT_MASK, 32'h4);
    dbg <= 1'b1;
    @(posedge aclk);
    dbg <= 1'b0;
    w8(3);
    ck(sec_nmi && irq && nmi_n === 8'h02);
    bus(1, A_EVT_MASK, 32'h0);
    w8(1);
    ck(!irq);
    bus(1, A_EVT_STAT, 32'h4);
    bus(1, A_SYS_PEND, 32'h7);
    bus(1, A_EVT_MASK, 32'h4);
    w8(1);
    ck(!irq && !sec_nmi);
    bus(1, A_SYS_REQ, 32'h1);
    w8(1);
    ck(sec_nmi);
    bus(1, A_CHAN + 10'h30, 32'h0);
    bus(1, A_CHAN + 10'h30, 32'h2);
    bus(0, A_CHAN + 10'h30, 0);
    ck(d === 32'h1);
    bus(0, A_EVT_STAT, 0);
    ck(d[0] === 1'b1);
    bus(1, A_ISTR + 10'h14, 32'h80008);
    bus(1, A_CHAN + 10'h38, 32'h4);
    w8(1);
    ck(link_irq === 16'h4);
    bus(1, A_ISTR + 10'h10, 32'h8);
    bus(1, A_CHAN + 10'h3C, 32'h10004);
    bus(0, A_CHAN + 10'h30, 0);
    ck(d === 32'h1 && link_irq === 16'h0);
    bus(1, A_CHAN + 10'h3C, 32'h4);
    bus(0, A_CHAN + 10'h30, 0);
    ck(d === 32'h0 && link_irq === 16'h4);
    bus(1, 10'h3FC, 32'hFFFFFFFF);
    ck(rs === RESP_DECERR);
    bus(0, 10'h3FC, 0);
    ck(rs === RESP_DECERR && d === 32'h0);
    finish_test;
  end
endmodule
`default_nettype wire
